// file: hdl/tmr_mode_pkg.sv
// package for the timer mode and match-a status block
// holds register offsets, reset values and field positions
// assumes an 8-bit register port with byte offsets in the low address byte
package tmr_mode_pkg;

  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 3;
  localparam int COUNTER_W = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_TIMER_MODE_SELECT = 8'h62;
  localparam logic [ADDR_W-1:0] OFS_MATCH_A_STATUS_ENABLE = 8'h64;

  // ----------------------------------------------------------------
  // reset values and fixed-one bits
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_TIMER_MODE_SELECT = 8'h98;
  localparam logic [DATA_W-1:0] RST_MATCH_A_STATUS_ENABLE = 8'h88;
  localparam logic [DATA_W-1:0] ONES_TIMER_MODE_SELECT = 8'h98;
  localparam logic [DATA_W-1:0] ONES_MATCH_A_STATUS_ENABLE = 8'h88;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions, timer_mode_select
  // ----------------------------------------------------------------
  localparam int BIT_PHASE_COUNT_SELECT = 6;
  localparam int BIT_FLAG_DIRECTION_SELECT = 5;
  localparam int LSB_PULSE_MODE = 0;

  // ----------------------------------------------------------------
  // field positions, match_a_status_enable
  // ----------------------------------------------------------------
  localparam int LSB_MATCH_A_IRQ_EN = 4;
  localparam int LSB_MATCH_A_FLAG = 0;

  // ----------------------------------------------------------------
  // counter limits
  // ----------------------------------------------------------------
  localparam logic [COUNTER_W-1:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [COUNTER_W-1:0] COUNTER_ZERO = 16'h0000;
  localparam logic [COUNTER_W-1:0] COUNTER_ONE = 16'h0001;

endpackage

// file: hdl/tmr_mode_status.sv
// mode select, match-a status/enable and channel 2 counter of a 3-channel timer
// assumes match, capture, tick and clear events come from channel logic on MCLK_I
// and that the quadrature inputs are asynchronous pins
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - mode register loads 0x98 on reset/standby
// - mode bits 7,4,3 read one, ignore writes
// - bit 6 selects channel 2 phase counting
// - phase mode counts both edges of both inputs
// - phase mode overrides external edge and prescaler
// - clear, compare, capture and flags still work
// - bit 5: overflow only, else both directions
// - bits 2..0 select pulse mode per channel
// - pulse pin set on match a, cleared b
// - status register loads 0x88 on reset/standby
// - status bits 7,3 read one, ignore writes
// - bits 6..4 enable per-channel match-a interrupt
// - compare mode: equality sets channel flag
// - capture mode: capture transfer sets channel flag
// - flag clears by read-one then write-zero
// - writing one to a flag has no effect
module tmr_mode_status #(
  parameter int CNT_W = tmr_mode_pkg::COUNTER_W
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic STANDBY_I,
  // register port
  input wire logic [tmr_mode_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [tmr_mode_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [tmr_mode_pkg::DATA_W-1:0] RDATA_O,
  // channel events
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_A_I,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_B_I,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] CAPTURE_A_I,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] A_IS_CAPTURE_I,
  // channel 2 counter control
  input wire logic COUNT_TICK_CH2_I,
  input wire logic CLEAR_CH2_I,
  output logic [CNT_W-1:0] COUNTER_CH2_O,
  output logic OVERFLOW_CH2_O,
  // quadrature pins
  input wire logic QUAD_INPUT_A_I,
  input wire logic QUAD_INPUT_B_I,
  // pulse pins
  output logic [tmr_mode_pkg::NUM_CH-1:0] PULSE_OUT_O,
  output logic [tmr_mode_pkg::NUM_CH-1:0] PULSE_OE_O,
  // interrupts
  output logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_A_IRQ_O,
  output logic IRQ_O
);
  import tmr_mode_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] qa_sync;
    logic [2:0] qb_sync;
    logic qa_lvl;
    logic qb_lvl;
    logic phase_count_select;
    logic flag_direction_select;
    logic [NUM_CH-1:0] pulse_mode;
    logic [NUM_CH-1:0] irq_en;
    logic [NUM_CH-1:0] flag;
    logic [NUM_CH-1:0] armed;
    logic [CNT_W-1:0] counter;
    logic [NUM_CH-1:0] pulse_out;
    logic overflow;
    logic [NUM_CH-1:0] irq_ch;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // read image of the mode register
  function automatic logic [DATA_W-1:0] mode_image(input state_t s);
    logic [DATA_W-1:0] v;
    v = ONES_TIMER_MODE_SELECT;
    v[BIT_PHASE_COUNT_SELECT] = s.phase_count_select;
    v[BIT_FLAG_DIRECTION_SELECT] = s.flag_direction_select;
    v[LSB_PULSE_MODE +: NUM_CH] = s.pulse_mode;
    return v;
  endfunction

  // read image of the match-a status/enable register
  function automatic logic [DATA_W-1:0] status_image(input state_t s);
    logic [DATA_W-1:0] v;
    v = ONES_MATCH_A_STATUS_ENABLE;
    v[LSB_MATCH_A_IRQ_EN +: NUM_CH] = s.irq_en;
    v[LSB_MATCH_A_FLAG +: NUM_CH] = s.flag;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // decode and event terms
  // ----------------------------------------------------------------
  logic sel_mode;
  logic sel_status;
  logic qa_new;
  logic qb_new;
  logic qa_edge;
  logic qb_edge;
  logic quad_step;
  logic quad_up;
  logic step;
  logic up;
  logic [NUM_CH-1:0] flag_set;
  logic [NUM_CH-1:0] flag_clr;

  // register select from address
  assign sel_mode = (ADDR_I == OFS_TIMER_MODE_SELECT);
  assign sel_status = (ADDR_I == OFS_MATCH_A_STATUS_ENABLE);

  // filtered pin levels: a change counts once stages two and three agree
  assign qa_new = (state_q.qa_sync[1] == state_q.qa_sync[2]) ? state_q.qa_sync[2] :
                  state_q.qa_lvl;
  assign qb_new = (state_q.qb_sync[1] == state_q.qb_sync[2]) ? state_q.qb_sync[2] :
                  state_q.qb_lvl;
  assign qa_edge = qa_new ^ state_q.qa_lvl;
  assign qb_edge = qb_new ^ state_q.qb_lvl;

  // quadrature decode; a double change is an illegal jump and is dropped
  always_comb begin
    quad_step = qa_edge ^ qb_edge;
    quad_up = 1'b0;
    if (qa_edge) begin
      quad_up = (qa_new != state_q.qb_lvl);
    end else if (qb_edge) begin
      quad_up = (qb_new == state_q.qa_lvl);
    end
  end

  // count source: phase mode takes precedence over the external tick
  assign step = state_q.phase_count_select ? quad_step : COUNT_TICK_CH2_I;
  assign up = state_q.phase_count_select ? quad_up : 1'b1;

  // flag events: compare equality or capture transfer
  assign flag_set = (MATCH_A_I & ~A_IS_CAPTURE_I)
                  | (CAPTURE_A_I & A_IS_CAPTURE_I);

  // clear request: zero written to an armed flag, ones ignored
  assign flag_clr = (WR_I && sel_status) ?
                    (state_q.armed & ~WDATA_I[LSB_MATCH_A_FLAG +: NUM_CH]) :
                    '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // pin synchronisers
    state_d.qa_sync = {state_q.qa_sync[1:0], QUAD_INPUT_A_I};
    state_d.qb_sync = {state_q.qb_sync[1:0], QUAD_INPUT_B_I};
    state_d.qa_lvl = qa_new;
    state_d.qb_lvl = qb_new;

    // register writes
    if (WR_I && sel_mode) begin
      state_d.phase_count_select = WDATA_I[BIT_PHASE_COUNT_SELECT];
      state_d.flag_direction_select = WDATA_I[BIT_FLAG_DIRECTION_SELECT];
      state_d.pulse_mode = WDATA_I[LSB_PULSE_MODE +: NUM_CH];
    end
    if (WR_I && sel_status) begin
      state_d.irq_en = WDATA_I[LSB_MATCH_A_IRQ_EN +: NUM_CH];
      state_d.armed = '0; // any write ends the clear sequence
    end

    // reading a set flag arms its clear
    if (RD_I && sel_status) begin
      state_d.armed = state_q.armed | state_q.flag;
    end

    // set wins over clear
    state_d.flag = (state_q.flag & ~flag_clr) | flag_set;

    // channel 2 counter: clear, then count
    state_d.overflow = 1'b0;
    if (CLEAR_CH2_I) begin
      state_d.counter = COUNTER_ZERO;
    end else if (step) begin
      if (up) begin
        state_d.counter = state_q.counter + COUNTER_ONE;
        state_d.overflow = (state_q.counter == COUNTER_MAX);
      end else begin
        state_d.counter = state_q.counter - COUNTER_ONE;
        state_d.overflow = (state_q.counter == COUNTER_ZERO) &&
                           !state_q.flag_direction_select;
      end
    end

    // pulse outputs: set on match a, clear on match b
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (!state_q.pulse_mode[ch]) begin
        state_d.pulse_out[ch] = 1'b0;
      end else if (MATCH_A_I[ch]) begin
        state_d.pulse_out[ch] = 1'b1;
      end else if (MATCH_B_I[ch]) begin
        state_d.pulse_out[ch] = 1'b0;
      end
    end

    // standby returns both registers to their reset image
    if (STANDBY_I) begin
      state_d.phase_count_select = RST_TIMER_MODE_SELECT[BIT_PHASE_COUNT_SELECT];
      state_d.flag_direction_select = RST_TIMER_MODE_SELECT[BIT_FLAG_DIRECTION_SELECT];
      state_d.pulse_mode = RST_TIMER_MODE_SELECT[LSB_PULSE_MODE +: NUM_CH];
      state_d.irq_en = RST_MATCH_A_STATUS_ENABLE[LSB_MATCH_A_IRQ_EN +: NUM_CH];
      state_d.flag = RST_MATCH_A_STATUS_ENABLE[LSB_MATCH_A_FLAG +: NUM_CH];
      state_d.armed = '0;
      state_d.pulse_out = '0;
    end

    // interrupts follow the registered flags and enables
    state_d.irq_ch = state_d.flag & state_d.irq_en;
    state_d.irq = |state_d.irq_ch;

    // read data, valid the cycle after the strobe
    if (RD_I && sel_mode) begin
      state_d.rdata = mode_image(state_q);
    end else if (RD_I && sel_status) begin
      state_d.rdata = status_image(state_q);
    end else begin
      state_d.rdata = READ_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state_q <= '0;
      state_q.phase_count_select <= RST_TIMER_MODE_SELECT[BIT_PHASE_COUNT_SELECT];
      state_q.flag_direction_select <= RST_TIMER_MODE_SELECT[BIT_FLAG_DIRECTION_SELECT];
      state_q.pulse_mode <= RST_TIMER_MODE_SELECT[LSB_PULSE_MODE +: NUM_CH];
      state_q.irq_en <= RST_MATCH_A_STATUS_ENABLE[LSB_MATCH_A_IRQ_EN +: NUM_CH];
      state_q.flag <= RST_MATCH_A_STATUS_ENABLE[LSB_MATCH_A_FLAG +: NUM_CH];
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA_O = state_q.rdata;
  assign COUNTER_CH2_O = state_q.counter;
  assign OVERFLOW_CH2_O = state_q.overflow;
  assign PULSE_OUT_O = state_q.pulse_out;
  assign PULSE_OE_O = state_q.pulse_mode;
  assign MATCH_A_IRQ_O = state_q.irq_ch;
  assign IRQ_O = state_q.irq;

endmodule
`default_nettype wire

// file: sim/tmr_mode_status_sva.sv
// assertions on the ports of the timer mode and match-a status block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module tmr_mode_status_sva
  import tmr_mode_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic STANDBY_I,
  // register port
  input wire logic [tmr_mode_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [tmr_mode_pkg::DATA_W-1:0] RDATA_O,
  // events and outputs
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_A_I,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_B_I,
  input wire logic [CNT_W-1:0] COUNTER_CH2_O,
  input wire logic OVERFLOW_CH2_O,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] PULSE_OUT_O,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] PULSE_OE_O,
  input wire logic [tmr_mode_pkg::NUM_CH-1:0] MATCH_A_IRQ_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // register images and reset
  reset_image_a: assert property (disable iff (1'b0) !RESETN_I |=> RDATA_O == 8'h00 && !IRQ_O)
    else $error("reset image wrong");
  mode_ones_a: assert property (RD_I && ADDR_I == OFS_TIMER_MODE_SELECT |=>
    (RDATA_O & ONES_TIMER_MODE_SELECT) == ONES_TIMER_MODE_SELECT) else $error("mode fixed bits");
  status_ones_a: assert property (RD_I && ADDR_I == OFS_MATCH_A_STATUS_ENABLE |=>
    (RDATA_O & ONES_MATCH_A_STATUS_ENABLE) == ONES_MATCH_A_STATUS_ENABLE) else $error("status bits");
  standby_quiet_a: assert property (STANDBY_I |=> !IRQ_O && PULSE_OE_O == 3'h0)
    else $error("standby left outputs active");
  irq_merge_a: assert property (IRQ_O == (|MATCH_A_IRQ_O))
    else $error("irq not or of channels");
  // pulse pins and counter wrap
  pulse_set_a: assert property (PULSE_OE_O[0] && MATCH_A_I[0] && !WR_I && !STANDBY_I
    |=> PULSE_OUT_O[0]) else $error("pulse not set");
  pulse_clear_a: assert property (PULSE_OE_O[0] && MATCH_B_I[0] && !MATCH_A_I[0] && !WR_I
    && !STANDBY_I |=> !PULSE_OUT_O[0]) else $error("pulse not cleared");
  pulse_off_a: assert property (!PULSE_OE_O[0] && !$past(PULSE_OE_O[0]) |-> !PULSE_OUT_O[0])
    else $error("pulse driven outside pulse mode");
  wrap_value_a: assert property (OVERFLOW_CH2_O |-> COUNTER_CH2_O == '0 || COUNTER_CH2_O == '1)
    else $error("overflow without wrap");
endmodule
`default_nettype wire

// file: sim/quad_pins_model.sv
// encoder model driving the channel 2 quadrature pins
// assumes steps are spaced wider than the pin filter
`timescale 1ns/100ps
`default_nettype none
module quad_pins_model (
  // clock, reset and step requests
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic up_i,
  input wire logic dn_i,
  // encoder pins
  output logic qa_o,
  output logic qb_o
);
  logic [1:0] phase_q;
  // one pin moves per step, order 00 10 11 01 is upward
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) phase_q <= 2'h0;
    else if (up_i) phase_q <= phase_q + 2'h1;
    else if (dn_i) phase_q <= phase_q - 2'h1;
  end
  // gray decode so both pins never change together
  assign qa_o = phase_q[1] ^ phase_q[0];
  assign qb_o = phase_q[1];
endmodule
`default_nettype wire

// file: sim/tb_tmr_mode_status.sv
// self-checking bench for the timer mode and match-a status block
// drives register port, channel events, counter strobes and encoder model
`timescale 1ns/100ps
`default_nettype none
module tb_tmr_mode_status;
  import tmr_mode_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, stby = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, clr = 1'b0;
  logic up = 1'b0, dn = 1'b0, qa, qb, ovf, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] ma = 3'h0, mb = 3'h0, cap = 3'h0, is_cap = 3'h0, pout, poe, irqv;
  logic [15:0] cnt;
  int miscompares = 0;
  int compares = 0;
  int ovf_cnt = 0;
  tmr_mode_status dut (.MCLK_I(clk), .RESETN_I(rst_n), .STANDBY_I(stby), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MATCH_A_I(ma), .MATCH_B_I(mb),
    .CAPTURE_A_I(cap), .A_IS_CAPTURE_I(is_cap), .COUNT_TICK_CH2_I(tick), .CLEAR_CH2_I(clr),
    .COUNTER_CH2_O(cnt), .OVERFLOW_CH2_O(ovf), .QUAD_INPUT_A_I(qa), .QUAD_INPUT_B_I(qb),
    .PULSE_OUT_O(pout), .PULSE_OE_O(poe), .MATCH_A_IRQ_O(irqv), .IRQ_O(irq));
  quad_pins_model partner (.clk_i(clk), .rst_n_i(rst_n), .up_i(up), .dn_i(dn), .qa_o(qa),
    .qb_o(qb));
  // clock and overflow pulse counter
  initial forever #4 clk = ~clk;
  always @(negedge clk) if (ovf === 1'b1) ovf_cnt++;
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic ev(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    @(posedge clk);
    {ma, mb, cap} <= {a, b, c};
    @(posedge clk);
    {ma, mb, cap} <= 9'h000;
    #1;
  endtask
  task automatic strobe(input logic t, input logic c);
    @(posedge clk);
    {tick, clr} <= {t, c};
    @(posedge clk);
    {tick, clr} <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic u, input int n);
    repeat (n) begin
      @(posedge clk);
      {up, dn} <= {u, ~u};
      @(posedge clk);
      {up, dn} <= 2'h0;
      repeat (8) @(posedge clk);
    end
    #1;
  endtask
  task automatic t_regs();
    rd_chk(OFS_TIMER_MODE_SELECT, 8'h98);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'h88);
    wr_reg(8'h10, 8'hFF);
    rd_chk(8'h10, READ_UNMAPPED);
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h00);
    rd_chk(OFS_TIMER_MODE_SELECT, 8'h98);
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h67);
    rd_chk(OFS_TIMER_MODE_SELECT, 8'hFF);
    wr_reg(OFS_MATCH_A_STATUS_ENABLE, 8'h77);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'hF8);
  endtask
  task automatic t_flags();
    @(posedge clk);
    is_cap <= 3'h2;
    ev(3'h3, 3'h0, 3'h0);
    chk("irq", irqv, 3'h1);
    ev(3'h0, 3'h0, 3'h2);
    chk("irq", irqv, 3'h3);
    wr_reg(OFS_MATCH_A_STATUS_ENABLE, 8'hF0);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'hFB);
    wr_reg(OFS_MATCH_A_STATUS_ENABLE, 8'hF2);
    #1 chk("irq", irqv, 3'h2);
    wr_reg(OFS_MATCH_A_STATUS_ENABLE, 8'h8A);
    #1 chk("irq", {irq, irqv}, 4'h0);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'h8A);
    wr_reg(OFS_MATCH_A_STATUS_ENABLE, 8'hF0);
    ev(3'h1, 3'h0, 3'h0);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'hF9);
    @(posedge clk);
    {wr, addr, wdata, ma} <= {1'b1, OFS_MATCH_A_STATUS_ENABLE, 8'hF0, 3'h1};
    @(posedge clk);
    {wr, ma} <= 4'h0;
    #1 chk("irq", irqv, 3'h1);
  endtask
  task automatic t_pulse();
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h99);
    ev(3'h1, 3'h0, 3'h0);
    chk("pulse", {poe, pout}, 6'h09);
    ev(3'h0, 3'h1, 3'h0);
    chk("pulse", pout, 3'h0);
    ev(3'h1, 3'h1, 3'h0);
    chk("pulse", pout, 3'h1);
    @(posedge clk);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    rd_chk(OFS_TIMER_MODE_SELECT, 8'h98);
    rd_chk(OFS_MATCH_A_STATUS_ENABLE, 8'h88);
    chk("pulse", {poe, pout, irq}, 7'h00);
  endtask
  task automatic t_quad();
    int n0;
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h40);
    n0 = ovf_cnt;
    step(1'b0, 1);
    chk("count", cnt, 16'hFFFF);
    step(1'b1, 1);
    chk("count", cnt, 16'h0000);
    chk("overflow", 16'(ovf_cnt - n0), 16'h0002);
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h60);
    n0 = ovf_cnt;
    step(1'b0, 1);
    step(1'b1, 3);
    chk("count", cnt, 16'h0002);
    chk("overflow", 16'(ovf_cnt - n0), 16'h0001);
    strobe(1'b1, 1'b0);
    chk("count", cnt, 16'h0002);
    strobe(1'b0, 1'b1);
    chk("count", cnt, 16'h0000);
    wr_reg(OFS_TIMER_MODE_SELECT, 8'h00);
    strobe(1'b1, 1'b0);
    step(1'b1, 1);
    chk("count", cnt, 16'h0001);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_flags();
    t_pulse();
    t_quad();
    end_of_test();
  end
  // watchdog well beyond the run length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
bind tmr_mode_status tmr_mode_status_sva #(.CNT_W(CNT_W)) sva (.MCLK_I(MCLK_I),
  .RESETN_I(RESETN_I), .STANDBY_I(STANDBY_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .MATCH_A_I(MATCH_A_I), .MATCH_B_I(MATCH_B_I),
  .COUNTER_CH2_O(COUNTER_CH2_O), .OVERFLOW_CH2_O(OVERFLOW_CH2_O), .PULSE_OUT_O(PULSE_OUT_O),
  .PULSE_OE_O(PULSE_OE_O), .MATCH_A_IRQ_O(MATCH_A_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire
